/* File: core/bpl_consts.vh */
// Constants for the break-point lineariser: table limits, defaults and encodings.
//----------------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------------
// Summary of operation
// - Insert places new point before selected one.
// - Insert leaves existing point values unchanged.
// - Points after insertion move up one index.
// - Remove joins neighbours; later indices drop one.
// - Never fewer than two break-points.
// - Show selected index and point count.
// - Point current entered as numeric milliamps; the code takes i_edit_value in microamps.
// - Each point holds current and display value.
// - Flag error unless strictly between neighbours.
// - Below first point use first slope.
// - Above last point use last slope.
// - Range indication unaffected by lineariser.
// - Defaults reset sets point0 4 mA, 0.
// - Defaults reset sets point1 20 mA, 1000.
// - At most seventeen points, indices 0..16.
// - Point currents within 3.8 to 21.0 mA.
// - Rejected adjustment keeps the previous value.
`ifndef BPL_CONSTS_VH
`define BPL_CONSTS_VH
// Currents are in microamps (16 bits), display values signed 16-bit counts.
`define BPL_MAX_PTS     5'h11
`define BPL_MIN_PTS     5'h02
`define BPL_IDX_W       5
`define BPL_CUR_W       16
`define BPL_DSP_W       16
`define BPL_CUR_MIN     16'h0ed8
`define BPL_CUR_MAX     16'h5208
`define BPL_DEF_CUR0    16'h0fa0
`define BPL_DEF_CUR1    16'h4e20
`define BPL_DEF_DSP0    16'h0000
`define BPL_DEF_DSP1    16'h03e8
// Last step of the 34-step serial divide.
`define BPL_DIV_LAST    6'h21
`endif

/* File: core/bpl_lineariser.v */
// Break-point lineariser: editable table and piecewise-linear evaluation.
`timescale 1ns/1ps
`default_nettype none
`include "bpl_consts.vh"
module bpl_lineariser (
    // Clock and reset.
    input  wire        i_core_clk,
    input  wire        i_resetn,
    // Editing commands from the front panel, one-cycle pulses.
    input  wire [4:0]  i_sel_idx,
    input  wire        i_insert_point_cmd,
    input  wire        i_remove_point_cmd,
    input  wire        i_point_current_set,
    input  wire        i_point_display_value_set,
    input  wire        i_lineariser_defaults_reset,
    input  wire [15:0] i_edit_value,
    // Measured loop current in microamps and a start pulse.
    input  wire [15:0] i_meas_current,
    input  wire        i_meas_valid,
    // Edit display and error indication.
    output reg  [4:0]  o_sel_idx,
    output reg  [4:0]  o_point_count,
    output reg         o_order_error_flag,
    output reg         o_edit_done,
    // Linearised result.
    output reg  [15:0] o_display_value,
    output reg         o_display_valid
);
    // ------------------------------------------------------------------------
    // Table storage
    // ------------------------------------------------------------------------
    reg [15:0] cur_r [0:16];
    reg [15:0] dsp_r [0:16];
    reg [4:0]  cnt_r;
    reg [2:0]  st_r;
    reg [4:0]  seg_r;
    reg [15:0] x_r;
    reg signed [33:0] num_r;
    reg signed [17:0] den_r;
    integer k;

    // ------------------------------------------------------------------------
    // Evaluation states, one-hot
    // ------------------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_SCAN = 3'h2;
    localparam [2:0] ST_DIV  = 3'h4;

    // ------------------------------------------------------------------------
    // Edit decode
    // ------------------------------------------------------------------------
    // Neighbour indices of the point being set, for the order check.
    wire [4:0]  prv = i_sel_idx - 5'h01;
    wire [4:0]  nxt = i_sel_idx + 5'h01;
    wire        sel_ok = (i_sel_idx < cnt_r);
    wire        lo_ok = (i_sel_idx == 5'h00) || (i_edit_value > cur_r[prv]);
    wire        hi_ok = (nxt >= cnt_r) || (i_edit_value < cur_r[nxt]);
    wire        rng_ok = (i_edit_value >= `BPL_CUR_MIN) && (i_edit_value <= `BPL_CUR_MAX);
    wire        set_ok = sel_ok && lo_ok && hi_ok && rng_ok;
    wire        busy = (st_r != ST_IDLE);

    // ------------------------------------------------------------------------
    // Table edits
    // ------------------------------------------------------------------------
    // Point count after the edit taken at this edge; the count output follows it.
    reg  [4:0]  cnt_nxt;
    always @* begin
        cnt_nxt = cnt_r;
        if (i_lineariser_defaults_reset) begin
            cnt_nxt = `BPL_MIN_PTS;
        end else if (i_insert_point_cmd && !busy) begin
            if (sel_ok && cnt_r < `BPL_MAX_PTS)
                cnt_nxt = cnt_r + 5'h01;
        end else if (i_remove_point_cmd && !busy) begin
            if (sel_ok && cnt_r > `BPL_MIN_PTS)
                cnt_nxt = cnt_r - 5'h01;
        end
    end

    // Table edits; inserts and removes are ignored while an evaluation is running.
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (k = 0; k < 17; k = k + 1) begin
                cur_r[k] <= 16'h0000;
                dsp_r[k] <= 16'h0000;
            end
            cur_r[0] <= `BPL_DEF_CUR0;
            cur_r[1] <= `BPL_DEF_CUR1;
            cur_r[2] <= 16'h0000;
            dsp_r[1] <= `BPL_DEF_DSP1;
            cnt_r <= `BPL_MIN_PTS;
            o_order_error_flag <= 1'b0;
            o_edit_done <= 1'b0;
        end else begin
            o_edit_done <= 1'b0;
            cnt_r <= cnt_nxt;
            if (i_lineariser_defaults_reset) begin
                cur_r[0] <= `BPL_DEF_CUR0;
                dsp_r[0] <= `BPL_DEF_DSP0;
                cur_r[1] <= `BPL_DEF_CUR1;
                dsp_r[1] <= `BPL_DEF_DSP1;
                o_order_error_flag <= 1'b0;
                o_edit_done <= 1'b1;
            end else if (i_insert_point_cmd && !busy) begin
                // New point copies the selected one; its value is set afterwards.
                if (sel_ok && cnt_r < `BPL_MAX_PTS) begin
                    for (k = 1; k < 17; k = k + 1)
                        if (k > i_sel_idx && k <= cnt_r) begin
                            cur_r[k] <= cur_r[k-1];
                            dsp_r[k] <= dsp_r[k-1];
                        end
                end
                o_edit_done <= 1'b1;
            end else if (i_remove_point_cmd && !busy) begin
                if (sel_ok && cnt_r > `BPL_MIN_PTS) begin
                    for (k = 0; k < 16; k = k + 1)
                        if (k >= i_sel_idx && k < cnt_r - 1) begin
                            cur_r[k] <= cur_r[k+1];
                            dsp_r[k] <= dsp_r[k+1];
                        end
                end
                o_edit_done <= 1'b1;
            end else if (i_point_current_set) begin
                if (set_ok)
                    cur_r[i_sel_idx] <= i_edit_value;
                o_order_error_flag <= !set_ok;
                o_edit_done <= 1'b1;
            end else if (i_point_display_value_set) begin
                if (sel_ok)
                    dsp_r[i_sel_idx] <= i_edit_value;
                o_edit_done <= 1'b1;
            end
        end
    end

    // Edit display: selected index and count in use.
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sel_idx <= 5'h00;
            o_point_count <= `BPL_MIN_PTS;
        end else begin
            o_sel_idx <= i_sel_idx;
            o_point_count <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Evaluation: segment scan then serial divide
    // ------------------------------------------------------------------------
    reg [5:0]  div_cnt_r;
    reg [33:0] rem_r;
    reg [33:0] quo_r;
    reg        neg_r;
    wire [15:0] c0 = cur_r[seg_r];
    wire [15:0] c1 = cur_r[seg_r + 5'h01];
    wire signed [16:0] dx = $signed({1'b0, x_r}) - $signed({1'b0, c0});
    wire signed [16:0] dd = $signed({dsp_r[seg_r + 5'h01][15], dsp_r[seg_r + 5'h01]})
                          - $signed({dsp_r[seg_r][15], dsp_r[seg_r]});
    wire signed [33:0] prod = dx * dd;
    wire [33:0] abs_num = num_r[33] ? (~num_r + 34'h1) : num_r;
    wire [33:0] trial = {rem_r[32:0], abs_num[`BPL_DIV_LAST - div_cnt_r]};
    wire [33:0] dv = {16'h0000, den_r[17:0]};
    wire [15:0] base = dsp_r[seg_r];
    // Low quotient bits including the bit decided in the current divide step.
    wire        q_bit = (trial >= dv);
    wire [15:0] quo_lo = {quo_r[14:0], q_bit};

    // Evaluation state machine; the value is plain 16-bit.
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= ST_IDLE;
            seg_r <= 5'h00;
            x_r <= 16'h0000;
            num_r <= 34'h0;
            den_r <= 18'h0;
            div_cnt_r <= 6'h00;
            rem_r <= 34'h0;
            quo_r <= 34'h0;
            neg_r <= 1'b0;
            o_display_value <= 16'h0000;
            o_display_valid <= 1'b0;
        end else begin
            o_display_valid <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    if (i_meas_valid) begin
                        x_r <= i_meas_current;
                        seg_r <= 5'h00;
                        st_r <= ST_SCAN;
                    end
                end
                ST_SCAN: begin
                    // Below first point segment 0 is used, above last the final one.
                    if (seg_r + 5'h02 >= cnt_r || x_r <= c1) begin
                        num_r <= prod;
                        den_r <= {2'b00, c1 - c0};
                        neg_r <= prod[33];
                        rem_r <= 34'h0;
                        quo_r <= 34'h0;
                        div_cnt_r <= 6'h00;
                        st_r <= ST_DIV;
                    end else begin
                        seg_r <= seg_r + 5'h01;
                    end
                end
                ST_DIV: begin
                    if (trial >= dv) begin
                        rem_r <= trial - dv;
                        quo_r <= {quo_r[32:0], 1'b1};
                    end else begin
                        rem_r <= trial;
                        quo_r <= {quo_r[32:0], 1'b0};
                    end
                    div_cnt_r <= div_cnt_r + 6'h01;
                    if (div_cnt_r == `BPL_DIV_LAST) begin
                        // The quotient is a magnitude, so the sign is applied here.
                        o_display_value <= neg_r ? (base - quo_lo) : (base + quo_lo);
                        o_display_valid <= 1'b1;
                        st_r <= ST_IDLE;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end
endmodule // bpl_lineariser
`default_nettype wire

/* File: tb/bpl_lineariser_chk.sv */
// Port-level assertions for the break-point lineariser.
`timescale 1ns/1ps
`default_nettype none
module bpl_chk (
    input wire logic        i_core_clk, i_resetn, i_insert_point_cmd, i_remove_point_cmd,
    input wire logic        i_point_current_set, i_point_display_value_set,
    input wire logic        i_lineariser_defaults_reset, o_order_error_flag, o_edit_done,
    input wire logic [4:0]  i_sel_idx, o_sel_idx, o_point_count,
    input wire logic [15:0] i_edit_value
);
    // Any edit command and the commands that outrank a current write.
    wire logic ed = i_insert_point_cmd | i_remove_point_cmd | i_point_current_set
                  | i_point_display_value_set | i_lineariser_defaults_reset;
    wire logic hi = i_insert_point_cmd | i_remove_point_cmd | i_lineariser_defaults_reset;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    property p_done; ed |=> o_edit_done; endproperty
    a_done: assert property (p_done) else $error("edit done missing");
    property p_sel; o_sel_idx == $past(i_sel_idx); endproperty
    a_sel: assert property (p_sel) else $error("index not shown");
    property p_cnt; o_point_count >= 5'h02 && o_point_count <= 5'h11; endproperty
    a_cnt: assert property (p_cnt) else $error("count out of bounds");
    property p_dflt; i_lineariser_defaults_reset |=> o_point_count == 5'h02 && !o_order_error_flag;
    endproperty
    a_dflt: assert property (p_dflt) else $error("defaults not restored");
    property p_cchg; o_point_count != $past(o_point_count) |-> $past(hi); endproperty
    a_cchg: assert property (p_cchg) else $error("count changed alone");
    property p_floor; i_remove_point_cmd && !i_insert_point_cmd && !i_lineariser_defaults_reset
        && o_point_count == 5'h02 |=> o_point_count == 5'h02; endproperty
    a_floor: assert property (p_floor) else $error("table below two");
    property p_range; i_point_current_set && !hi
        && (i_edit_value < 16'h0ed8 || i_edit_value > 16'h5208) |=> o_order_error_flag; endproperty
    a_range: assert property (p_range) else $error("range error missed");
    property p_flag; o_order_error_flag != $past(o_order_error_flag)
        |-> $past(i_point_current_set | i_lineariser_defaults_reset); endproperty
    a_flag: assert property (p_flag) else $error("flag changed alone");
endmodule // bpl_chk
bind bpl_lineariser bpl_chk bpl_chk_inst (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_insert_point_cmd(i_insert_point_cmd), .i_remove_point_cmd(i_remove_point_cmd),
    .i_point_current_set(i_point_current_set), .i_edit_value(i_edit_value),
    .i_point_display_value_set(i_point_display_value_set), .i_sel_idx(i_sel_idx),
    .i_lineariser_defaults_reset(i_lineariser_defaults_reset), .o_sel_idx(o_sel_idx),
    .o_order_error_flag(o_order_error_flag), .o_edit_done(o_edit_done),
    .o_point_count(o_point_count));
`default_nettype wire

/* File: tb/bpl_panel.sv */
// Front-panel display model that shows what the indicator presents.
`timescale 1ns/1ps
`default_nettype none
module bpl_panel (
    input wire logic        i_core_clk, i_valid,
    input wire logic [15:0] i_value,
    input wire logic [4:0]  i_idx, i_cnt,
    output logic     [15:0] o_shown,
    output logic     [9:0]  o_edit_pair
);
    // Index and count appear side by side while editing.
    assign o_edit_pair = {i_idx, i_cnt};
    // The last reading stays on the digits until the next one.
    always @(posedge i_core_clk) if (i_valid) o_shown <= i_value;
endmodule // bpl_panel
`default_nettype wire

/* File: tb/tb_bpl_lineariser.sv */
// Self-checking bench for the break-point lineariser.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_bpl_lineariser;
    logic clk = 0, rstn = 0, ins = 0, rem = 0, cset = 0, dset = 0, dflt = 0, mv = 0;
    logic [4:0] sel = 0, osel, cnt;
    logic [15:0] ev = 0, mc = 0, dv, shown;
    logic flag, done, val;
    logic [9:0] pair;
    int err_total = 0, compares = 0, cyc = 0, n = 2;
    int mcur[17], mdsp[17];
    bpl_lineariser bpl_lineariser_inst (.i_core_clk(clk), .i_resetn(rstn), .i_sel_idx(sel),
        .i_insert_point_cmd(ins), .i_remove_point_cmd(rem), .i_point_current_set(cset),
        .i_point_display_value_set(dset), .i_lineariser_defaults_reset(dflt),
        .i_edit_value(ev), .i_meas_current(mc), .i_meas_valid(mv), .o_sel_idx(osel),
        .o_point_count(cnt), .o_order_error_flag(flag), .o_edit_done(done),
        .o_display_value(dv), .o_display_valid(val));
    bpl_panel bpl_panel_inst (.i_core_clk(clk), .i_valid(val), .i_value(dv), .i_idx(osel),
        .i_cnt(cnt), .o_shown(shown), .o_edit_pair(pair));
    // A 25 ns clock and a cycle ceiling that cuts a hang short.
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin err_total++; summarize(); end
    end
    // Piecewise-linear expectation from the bench copy of the table.
    function automatic logic [15:0] expv(int x);
        int k;
        k = 0;
        while (k < n - 2 && x >= mcur[k + 1]) k++;
        return 16'(mdsp[k] + (x - mcur[k]) * (mdsp[k + 1] - mdsp[k]) / (mcur[k + 1] - mcur[k]));
    endfunction
    // One edit pulse: 0 defaults, 1 insert, 2 remove, 3 current, 4 display.
    task automatic edit(int op, int idx, int v);
        int i;
        bit ok;
        @(posedge clk); #2;
        sel = 5'(idx); ev = 16'(v);
        {dflt, ins, rem, cset, dset} = 5'b10000 >> op;
        @(posedge clk); #2;
        {dflt, ins, rem, cset, dset} = 5'h00;
        if (op == 0) begin n = 2; mcur[0] = 4000; mdsp[0] = 0; mcur[1] = 20000; mdsp[1] = 1000; end
        if (op == 1 && n < 17 && idx < n) begin
            for (i = n; i > idx; i--) begin mcur[i] = mcur[i-1]; mdsp[i] = mdsp[i-1]; end
            n++;
        end
        if (op == 2 && n > 2 && idx < n) begin
            n--;
            for (i = idx; i < n; i++) begin mcur[i] = mcur[i+1]; mdsp[i] = mdsp[i+1]; end
        end
        ok = v >= 3800 && v <= 21000 && (idx == 0 || v > mcur[idx-1]) && (idx == n-1 || v < mcur[idx+1]);
        if (op == 3 && ok) mcur[idx] = v;
        if (op == 4) mdsp[idx] = v;
        if (op == 0 || op == 3) `CHK("flag", 1'(op == 3 && !ok), flag)
        `CHK("edit_done", 1'b1, done)
        `CHK("count", 5'(n), cnt)
        $display("test edit %0d at %0d ends", op, idx);
    endtask
    // One evaluation; the result is waited for under a bound.
    task automatic meas(int x);
        int i;
        logic [15:0] e;
        e = expv(x);
        @(posedge clk); #2;
        mc = 16'(x); mv = 1;
        @(posedge clk); #2;
        mv = 0;
        for (i = 0; i < 80 && val !== 1'b1; i++) begin @(posedge clk); #2; end
        `CHK("valid", 1'b1, val)
        `CHK("value", e, dv)
        @(posedge clk); #2;
        `CHK("shown", e, shown)
        $display("test reading %0d ends", x);
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Main sequence: defaults, edges of the table, refusals and a full table.
    initial begin
        void'($urandom(93));
        repeat (16) @(posedge clk);
        #2 rstn = 1;
        `CHK("rst_count", 5'h02, cnt)
        edit(0, 0, 0);
        meas(4000);
        meas(20000);
        meas(3000);
        meas(21500);
        repeat (4) meas(3800 + $urandom % 17201);
        edit(1, 1, 0);
        edit(3, 1, 9000 + $urandom % 4000);
        edit(4, 1, $urandom % 800);
        repeat (5) meas(3000 + $urandom % 19500);
        edit(3, 1, 25000);
        edit(3, 1, 3700);
        edit(3, 1, 4000);
        edit(3, 1, 20000);
        edit(3, 2, 4500);
        edit(3, 0, 3800);
        meas(8000);
        meas(2500);
        edit(2, 1, 0);
        meas(12000);
        edit(2, 0, 0);
        repeat (16) edit(1, 1, 0);
        `CHK("pair", {5'h01, 5'h11}, pair)
        edit(0, 0, 0);
        meas(12000);
        summarize();
    end
endmodule // tb_bpl_lineariser
`default_nettype wire
